// ### rtl/ppr_defines.svh
`ifndef PPR_DEFINES_SVH
`define PPR_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register offsets relative to the port base address
// ----------------------------------------------------------------------------
`define PPR_OFF_DATA      16'h0000
`define PPR_OFF_STATUS    16'h0001
`define PPR_OFF_CONTROL   16'h0002
`define PPR_OFF_FIFO      16'h0400
`define PPR_OFF_CFGB      16'h0401
`define PPR_OFF_ECR       16'h0402

// ----------------------------------------------------------------------------
// Mode field codes
// ----------------------------------------------------------------------------
`define PPR_MODE_SPP      3'h0
`define PPR_MODE_BIDIR    3'h1
`define PPR_MODE_COMPAT_FIFO_PORT    3'h2
`define PPR_MODE_ECP      3'h3
`define PPR_MODE_TEST     3'h6
`define PPR_MODE_CONFIG   3'h7

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define PPR_CTL_STROBE    0
`define PPR_CTL_AUTOFEED  1
`define PPR_CTL_INIT      2
`define PPR_CTL_SELIN     3
`define PPR_CTL_ACKIEN    4
`define PPR_CTL_DIR       5
`define PPR_ECR_MODE_HI   7
`define PPR_ECR_MODE_LO   5
`define PPR_ECR_ERRDIS    4
`define PPR_ECR_DMAEN     3
`define PPR_ECR_SVC       2
`define PPR_ECR_FULL      1
`define PPR_ECR_EMPTY     0
`define PPR_ST_FAULT      3
`define PPR_ST_SELECT     4
`define PPR_ST_PERR       5
`define PPR_ST_ACK        6
`define PPR_ST_BUSY       7

// ----------------------------------------------------------------------------
// Reset values and constants
// ----------------------------------------------------------------------------
`define PPR_DATA_RST      8'h00
`define PPR_CTRL_RST      6'h00
`define PPR_MODE_RST      3'h0
`define PPR_SVC_RST       1'b1
`define PPR_CFGA_VALUE    8'h10
// Fault and acknowledge pins idle high, so their synchroniser bits reset high.
`define PPR_SYNC_RST      13'h0900

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define PPR_CLK_NS        50
`define PPR_SETUP_NS      500
`define PPR_STROBE_NS     500
`define PPR_SETUP_CYC     ((`PPR_SETUP_NS + `PPR_CLK_NS - 1) / `PPR_CLK_NS)
`define PPR_STROBE_CYC    ((`PPR_STROBE_NS + `PPR_CLK_NS - 1) / `PPR_CLK_NS)

`endif

// ### rtl/ppr_pkg.sv
package ppr_pkg;

	typedef logic [2:0] ppr_mode_t;

	typedef enum logic [2:0]
	{
		ST_IDLE,
		ST_LOAD,
		ST_SETUP,
		ST_STROBE,
		ST_RELEASE,
		ST_REV_ACK
	} ppr_state_t;

endpackage

// ### rtl/ppr_fifo_mem.sv
`timescale 1ns/1ns
`default_nettype none

module ppr_fifo_mem #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16,
	parameter int AW    = 4
) (
	input  wire logic             core_clk, // System clock.
	input  wire logic             arst_n,   // Asynchronous reset, active low.
	input  wire logic             wr_en,    // Write strobe.
	input  wire logic [AW-1:0]    waddr,    // Write address.
	input  wire logic [WIDTH-1:0] wdata,    // Write data.
	input  wire logic [AW-1:0]    raddr,    // Read address.
	output logic      [WIDTH-1:0] rdata     // Registered read data.
);

	logic [WIDTH-1:0] mem [DEPTH];

	initial
	begin
		if (DEPTH > (1 << AW) || DEPTH < 2)
			$error("ppr_fifo_mem: DEPTH does not fit AW");
	end

	always_ff @(posedge core_clk)
	begin
		if (wr_en)
			mem[waddr] <= wdata;
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			rdata <= '0;
		else
			rdata <= mem[raddr];
	end

endmodule

`default_nettype wire

// ### rtl/ppr_port.sv
`timescale 1ns/1ns
`default_nettype none
`include "ppr_defines.svh"

// Contract
// - Offsets decode relative to the port base.
// - Mode field picks which register answers.
// - Data latch resets; writes drive pins.
// - Data reads in modes 000/001 return pins.
// - Mode 011 forward offset zero pushes tagged entry.
// - Status bits 0 to 2 read zero.
// - Status 3..6 show live cable inputs.
// - Status bit 7 is inverted busy.
// - Control 0..5 reset; 6,7 read zero.
// - Control 0,1,3 drive pins inverted (bit 0 outside 010 and 011 forward, bit 1 outside 011).
// - Control bit 2 drives initialize directly.
// - Acknowledge rise raises interrupt when enabled.
// - Direction bit, ignored in modes 000/010.
// - Mode 010 sends FIFO by standard handshake.
// - Mode 011 forward sends FIFO by ECP.
// - Mode 011 reverse fills FIFO from peripheral.
// - Test mode FIFO access without cable handshake.
// - Test FIFO drops overflow, rereads on underrun.
// - Full and empty always track true state.
// - Test mode sets service flag at thresholds.
// - FIFO reads take the head unless the FIFO is empty.
// - Mode held in extended control bits 7..5.
// - Mode 000 holds the FIFO empty.
// - Service flag sets on free space forward, fill level reverse, DMA terminal count.
module ppr_port #(
	parameter int DEPTH      = 16,
	parameter int WR_THRESH  = 8,
	parameter int RD_THRESH  = 8,
	parameter logic [2:0] CFG_IRQ_CODE = 3'h0, // Arbitrary value.
	parameter logic [2:0] CFG_DMA_CODE = 3'h0  // Arbitrary value.
) (
	input  wire logic        core_clk,            // System clock, 20 MHz.
	input  wire logic        arst_n,              // Asynchronous reset, active low.
	input  wire logic [15:0] port_base,           // Selected port base address.
	input  wire logic [15:0] host_addr,           // Host I/O address.
	input  wire logic        host_wr,             // Host write strobe, one cycle.
	input  wire logic        host_rd,             // Host read strobe, one cycle.
	input  wire logic [7:0]  host_wdata,          // Host write data.
	input  wire logic        dma_cycle_qualifier, // High during DMA cycles.
	input  wire logic        dma_ack,             // DMA acknowledge for the FIFO.
	input  wire logic        dma_tc,              // DMA terminal count pulse.
	output logic      [7:0]  host_rdata,          // Read reply data.
	output logic             host_rvalid,         // Read reply valid, one cycle.
	output logic             dma_req,             // DMA request level.
	output logic             port_irq,            // Acknowledge interrupt pulse.
	input  wire logic [7:0]  cable_data_pins_in,  // Data pin levels.
	output logic      [7:0]  cable_data_pins_out, // Data pin drive value.
	output logic             cable_data_pins_oe,  // Data pin output enable.
	input  wire logic        fault_in_n,          // Fault input.
	input  wire logic        select_status_in,    // Printer select input.
	input  wire logic        paper_error_in,      // Paper error input.
	input  wire logic        acknowledge_in_n,    // Acknowledge input.
	input  wire logic        busy_in,             // Printer busy input.
	output logic             strobe_out_n,        // Strobe pin.
	output logic             autofeed_out_n,      // Autofeed pin.
	output logic             initialize_out_n,    // Initialize pin.
	output logic             select_in_out_n      // Select-in pin.
);

	localparam int AW = $clog2(DEPTH);
	localparam logic [3:0] SETUP_CYC  = 4'(`PPR_SETUP_CYC);
	localparam logic [3:0] STROBE_CYC = 4'(`PPR_STROBE_CYC);

	initial
	begin
		if (DEPTH != 16)
			$error("ppr_port: DEPTH must be 16");
		if (WR_THRESH < 1 || WR_THRESH > DEPTH || RD_THRESH < 1 || RD_THRESH > DEPTH)
			$error("ppr_port: thresholds out of range");
		if (`PPR_SETUP_CYC > 15 || `PPR_STROBE_CYC > 15)
			$error("ppr_port: handshake counts exceed counter");
	end

	// ------------------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------------------
	logic [12:0] sync_a;
	logic [12:0] sync_b;
	logic [7:0]  pins_s;
	logic        fault_s;
	logic        select_s;
	logic        perr_s;
	logic        ack_s;
	logic        busy_s;
	logic        ack_prev;

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sync_a <= `PPR_SYNC_RST;
			sync_b <= `PPR_SYNC_RST;
		end
		else
		begin
			sync_a <= {busy_in, acknowledge_in_n, paper_error_in, select_status_in,
				fault_in_n, cable_data_pins_in};
			sync_b <= sync_a;
		end
	end

	assign pins_s   = sync_b[7:0];
	assign fault_s  = sync_b[8];
	assign select_s = sync_b[9];
	assign perr_s   = sync_b[10];
	assign ack_s    = sync_b[11];
	assign busy_s   = sync_b[12];

	// ------------------------------------------------------------------------
	// Access decode
	// ------------------------------------------------------------------------
	logic [7:0]        data_latch;
	logic [5:0]        ctrl;
	ppr_pkg::ppr_mode_t mode;
	logic              err_irq_dis;
	logic              dma_en;
	logic              service_irq_flag;
	logic [AW:0]       count;
	logic              full;
	logic              empty;
	logic [15:0]       offset;
	logic              io_wr;
	logic              io_rd;
	logic              dir_in;
	logic              fwd_compat;
	logic              fwd_ecp;
	logic              rev_on;
	logic              host_fill_mode;
	logic              host_drain_mode;

	assign offset = host_addr - port_base;
	assign io_wr  = host_wr && !dma_cycle_qualifier;
	assign io_rd  = host_rd && !dma_cycle_qualifier;
	assign full   = (count == (AW + 1)'(DEPTH));
	assign empty  = (count == '0);

	// Direction is forced outward in the two modes that cannot receive.
	assign dir_in = ctrl[`PPR_CTL_DIR] && mode != `PPR_MODE_SPP
		&& mode != `PPR_MODE_COMPAT_FIFO_PORT;
	assign fwd_compat      = (mode == `PPR_MODE_COMPAT_FIFO_PORT);
	assign fwd_ecp         = (mode == `PPR_MODE_ECP) && !dir_in;
	assign rev_on          = (mode == `PPR_MODE_ECP) && dir_in;
	assign host_fill_mode  = fwd_compat || fwd_ecp || (mode == `PPR_MODE_TEST);
	assign host_drain_mode = rev_on || (mode == `PPR_MODE_TEST);

	logic wr_data;
	logic wr_atag;
	logic wr_fifo;
	logic wr_ctrl;
	logic wr_ecr;
	logic rd_fifo_req;

	assign wr_data = io_wr && offset == `PPR_OFF_DATA
		&& (mode == `PPR_MODE_SPP || mode == `PPR_MODE_BIDIR);
	// The address-tagged entry is only meaningful going forward.
	assign wr_atag = io_wr && offset == `PPR_OFF_DATA && fwd_ecp;
	assign wr_fifo = host_fill_mode && host_wr
		&& ((dma_cycle_qualifier && dma_ack) || (io_wr && offset == `PPR_OFF_FIFO));
	assign wr_ctrl = io_wr && offset == `PPR_OFF_CONTROL;
	assign wr_ecr  = io_wr && offset == `PPR_OFF_ECR;
	assign rd_fifo_req = host_drain_mode && host_rd
		&& ((dma_cycle_qualifier && dma_ack) || (io_rd && offset == `PPR_OFF_FIFO));

	// ------------------------------------------------------------------------
	// FIFO
	// ------------------------------------------------------------------------
	ppr_pkg::ppr_state_t state;
	logic [AW-1:0]       wr_ptr;
	logic [AW-1:0]       rd_ptr;
	logic [8:0]          head;
	logic                fsm_pop;
	logic                rev_push;
	logic                push;
	logic [8:0]          push_word;
	logic                push_ok;
	logic                pop_ok;
	logic                flush;

	assign fsm_pop  = (state == ppr_pkg::ST_IDLE) && (fwd_compat || fwd_ecp) && !empty;
	assign rev_push = (state == ppr_pkg::ST_IDLE) && rev_on && !ack_s && !full;
	// Reverse capture busy low marks a command byte.
	assign push      = rev_push || ((wr_fifo || wr_atag) && !rev_on);
	assign push_word = rev_push ? {!busy_s, pins_s} : {wr_atag, host_wdata};
	assign push_ok   = push && !full;
	assign pop_ok    = (fsm_pop || rd_fifo_req) && !empty;
	assign flush     = (mode == `PPR_MODE_SPP);

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end
		else if (flush)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end
		else
		begin
			if (push_ok)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop_ok)
				rd_ptr <= rd_ptr + 1'b1;
			if (push_ok && !pop_ok)
				count <= count + 1'b1;
			else if (pop_ok && !push_ok)
				count <= count - 1'b1;
		end
	end

	ppr_fifo_mem #(
		.WIDTH (9),
		.DEPTH (DEPTH),
		.AW    (AW)
	) u_mem (
		.core_clk (core_clk),
		.arst_n   (arst_n),
		.wr_en    (push_ok),
		.waddr    (wr_ptr),
		.wdata    (push_word),
		.raddr    (rd_ptr),
		.rdata    (head)
	);

	// ------------------------------------------------------------------------
	// Host registers
	// ------------------------------------------------------------------------
	logic svc_set;
	logic [AW:0] free_space;

	assign free_space = (AW + 1)'(DEPTH) - count;

	always_comb
	begin
		svc_set = 1'b0;
		if (!service_irq_flag && host_fill_mode | host_drain_mode)
		begin
			if (dma_en)
				svc_set = dma_tc;
			else if (dir_in)
				svc_set = (count >= (AW + 1)'(RD_THRESH));
			else
				svc_set = (free_space >= (AW + 1)'(WR_THRESH));
		end
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			data_latch <= `PPR_DATA_RST;
		else if (wr_data)
			data_latch <= host_wdata;
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			ctrl <= `PPR_CTRL_RST;
		else if (wr_ctrl)
			ctrl <= host_wdata[5:0];
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			mode        <= `PPR_MODE_RST;
			err_irq_dis <= 1'b0;
			dma_en      <= 1'b0;
		end
		else if (wr_ecr)
		begin
			mode        <= host_wdata[`PPR_ECR_MODE_HI:`PPR_ECR_MODE_LO];
			err_irq_dis <= host_wdata[`PPR_ECR_ERRDIS];
			dma_en      <= host_wdata[`PPR_ECR_DMAEN];
		end
	end

	// A hardware set in the same cycle as a clearing write wins.
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			service_irq_flag <= `PPR_SVC_RST;
		else if (svc_set)
			service_irq_flag <= 1'b1;
		else if (wr_ecr)
			service_irq_flag <= host_wdata[`PPR_ECR_SVC];
	end

	// ------------------------------------------------------------------------
	// Read reply, two edges after the strobe
	// ------------------------------------------------------------------------
	logic [7:0] rd_hold;
	logic       rd_pend;
	logic       rd_fifo;
	logic       rd_was_empty;
	logic [7:0] last_byte;
	logic [7:0] reg_value;

	always_comb
	begin
		reg_value = 8'h00;
		case (offset)
			`PPR_OFF_DATA:
				reg_value = (mode == `PPR_MODE_SPP || mode == `PPR_MODE_BIDIR)
					? pins_s : data_latch;
			`PPR_OFF_STATUS:
				reg_value = {!busy_s, ack_s, perr_s, select_s, fault_s, 3'h0};
			`PPR_OFF_CONTROL:
				reg_value = {2'h0, ctrl};
			`PPR_OFF_FIFO:
				reg_value = (mode == `PPR_MODE_CONFIG) ? `PPR_CFGA_VALUE : 8'h00;
			`PPR_OFF_CFGB:
				reg_value = (mode == `PPR_MODE_CONFIG)
					? {1'b0, port_irq, CFG_IRQ_CODE, CFG_DMA_CODE} : 8'h00;
			`PPR_OFF_ECR:
				reg_value = {mode, err_irq_dis, dma_en, service_irq_flag, full, empty};
			default:
				reg_value = 8'h00;
		endcase
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rd_pend      <= 1'b0;
			rd_fifo      <= 1'b0;
			rd_was_empty <= 1'b0;
			rd_hold      <= 8'h00;
		end
		else
		begin
			rd_pend      <= io_rd || rd_fifo_req;
			rd_fifo      <= rd_fifo_req;
			rd_was_empty <= empty;
			rd_hold      <= reg_value;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			host_rdata  <= 8'h00;
			host_rvalid <= 1'b0;
			last_byte   <= 8'h00;
		end
		else
		begin
			host_rvalid <= rd_pend;
			if (rd_fifo && rd_was_empty)
				host_rdata <= last_byte;
			else if (rd_fifo)
				host_rdata <= head[7:0];
			else
				host_rdata <= rd_hold;
			if (rd_fifo && !rd_was_empty)
				last_byte <= head[7:0];
		end
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			dma_req <= 1'b0;
		else
			dma_req <= dma_en && !service_irq_flag
				&& ((host_fill_mode && !dir_in && !full) || (host_drain_mode && dir_in && !empty));
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			ack_prev <= 1'b1;
		else
			ack_prev <= ack_s;
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			port_irq <= 1'b0;
		else
			port_irq <= ctrl[`PPR_CTL_ACKIEN] && ack_s && !ack_prev;
	end

	// ------------------------------------------------------------------------
	// Cable handshake
	// ------------------------------------------------------------------------
	logic [3:0] hs_cnt;
	logic [7:0] xfer_byte;
	logic       xfer_tag;
	logic       host_ack;

	// Test mode never enters the handshake, so the strobe pin follows control bit 0 there.
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state     <= ppr_pkg::ST_IDLE;
			hs_cnt    <= 4'h0;
			xfer_byte <= 8'h00;
			xfer_tag  <= 1'b0;
			host_ack  <= 1'b0;
		end
		else if (!(fwd_compat || fwd_ecp || rev_on))
		begin
			state    <= ppr_pkg::ST_IDLE;
			host_ack <= 1'b0;
		end
		else
		begin
			case (state)
				ppr_pkg::ST_IDLE:
				begin
					if (fsm_pop)
						state <= ppr_pkg::ST_LOAD;
					else if (rev_push)
					begin
						host_ack <= 1'b1;
						state    <= ppr_pkg::ST_REV_ACK;
					end
				end
				ppr_pkg::ST_LOAD:
				begin
					xfer_byte <= head[7:0];
					xfer_tag  <= head[8];
					hs_cnt    <= SETUP_CYC;
					state     <= ppr_pkg::ST_SETUP;
				end
				ppr_pkg::ST_SETUP:
				begin
					if (hs_cnt <= 4'h1)
					begin
						hs_cnt <= STROBE_CYC;
						state  <= ppr_pkg::ST_STROBE;
					end
					else
						hs_cnt <= hs_cnt - 4'h1;
				end
				ppr_pkg::ST_STROBE:
				begin
					if (hs_cnt != 4'h0)
						hs_cnt <= hs_cnt - 4'h1;
					if ((fwd_compat && hs_cnt <= 4'h1) || (fwd_ecp && busy_s))
						state <= ppr_pkg::ST_RELEASE;
				end
				ppr_pkg::ST_RELEASE:
				begin
					if (!busy_s)
						state <= ppr_pkg::ST_IDLE;
				end
				ppr_pkg::ST_REV_ACK:
				begin
					if (ack_s)
					begin
						host_ack <= 1'b0;
						state    <= ppr_pkg::ST_IDLE;
					end
				end
				default:
					state <= ppr_pkg::ST_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// Pin drivers
	// ------------------------------------------------------------------------
	logic in_xfer;

	assign in_xfer = (state == ppr_pkg::ST_SETUP) || (state == ppr_pkg::ST_STROBE)
		|| (state == ppr_pkg::ST_RELEASE);

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cable_data_pins_out <= 8'h00;
			cable_data_pins_oe  <= 1'b1;
			strobe_out_n        <= 1'b1;
			autofeed_out_n      <= 1'b1;
			initialize_out_n    <= 1'b0;
			select_in_out_n     <= 1'b1;
		end
		else
		begin
			if (in_xfer && (fwd_compat || fwd_ecp))
				cable_data_pins_out <= xfer_byte;
			else if (mode == `PPR_MODE_TEST)
				cable_data_pins_out <= last_byte;
			else
				cable_data_pins_out <= data_latch;
			cable_data_pins_oe <= !dir_in;
			if (fwd_compat || fwd_ecp)
				strobe_out_n <= (state != ppr_pkg::ST_STROBE);
			else
				strobe_out_n <= !ctrl[`PPR_CTL_STROBE];
			if (fwd_ecp)
				autofeed_out_n <= !xfer_tag;
			else if (rev_on)
				autofeed_out_n <= host_ack;
			else
				autofeed_out_n <= !ctrl[`PPR_CTL_AUTOFEED];
			initialize_out_n <= ctrl[`PPR_CTL_INIT];
			select_in_out_n  <= !ctrl[`PPR_CTL_SELIN];
		end
	end

endmodule

`default_nettype wire

// ### dv/ppr_port_assertions.sv
`timescale 1ns/1ns
`default_nettype none
// ----
// Host port checks
// ----
module ppr_port_assertions (
	input wire logic        core_clk,            // Clock.
	input wire logic        arst_n,              // Reset.
	input wire logic [15:0] port_base,           // Base.
	input wire logic [15:0] host_addr,           // Address.
	input wire logic        host_wr,             // Write.
	input wire logic        host_rd,             // Read.
	input wire logic [7:0]  host_wdata,          // Write data.
	input wire logic        dma_cycle_qualifier, // DMA cycle.
	input wire logic [7:0]  host_rdata,          // Read data.
	input wire logic        host_rvalid,         // Reply.
	input wire logic        port_irq,            // Interrupt.
	input wire logic        cable_data_pins_oe,  // Pin enable.
	input wire logic        strobe_out_n,        // Strobe.
	input wire logic        initialize_out_n     // Initialize.
);
	logic [15:0] off;
	logic [2:0]  mode;
	logic [2:0]  mode_q;
	logic        io_wr;
	logic        io_rd;
	assign off = host_addr - port_base;
	assign io_wr = host_wr && !dma_cycle_qualifier;
	assign io_rd = host_rd && !dma_cycle_qualifier;
	// Mode shadow, so that mode-dependent checks need no internal probe.
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			mode <= 3'h0;
		else if (io_wr && off == 16'h0402)
			mode <= host_wdata[7:5];
	end
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			mode_q <= 3'h0;
		else
			mode_q <= mode;
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	a_read_reply: assert property (io_rd |-> ##2 host_rvalid)
		else $error("read got no reply");
	a_reply_cause: assert property (host_rvalid |-> $past(host_rd, 2))
		else $error("reply without read");
	a_status_zero: assert property (io_rd && off == 16'h0001 |-> ##2 host_rdata[2:0] == 3'h0)
		else $error("status low bits set");
	a_ctrl_top_zero: assert property (io_rd && off == 16'h0002 |-> ##2 host_rdata[7:6] == 2'h0)
		else $error("control top bits set");
	a_strobe_inverted: assert property (io_wr && off == 16'h0002 && mode == 3'h0
		|-> ##2 strobe_out_n == !$past(host_wdata[0], 2))
		else $error("strobe pin wrong");
	a_init_direct: assert property (io_wr && off == 16'h0002 && mode == 3'h0
		|-> ##2 initialize_out_n == $past(host_wdata[2], 2))
		else $error("initialize pin wrong");
	a_irq_single: assert property (port_irq |=> !port_irq)
		else $error("interrupt longer than one cycle");
	a_spp_drives: assert property (mode == 3'h0 && mode_q == 3'h0 |-> cable_data_pins_oe)
		else $error("data pins released in mode 0");
	cover property (port_irq);
	cover property ($fell(strobe_out_n) && mode == 3'h2);
	cover property (io_rd && mode == 3'h6 && off == 16'h0400);
endmodule

bind ppr_port ppr_port_assertions u_chk (.core_clk, .arst_n, .port_base, .host_addr, .host_wr,
	.host_rd, .host_wdata, .dma_cycle_qualifier, .host_rdata, .host_rvalid, .port_irq,
	.cable_data_pins_oe, .strobe_out_n, .initialize_out_n);
`default_nettype wire

// ### dv/ppr_printer_model.sv
`timescale 1ns/1ns
`default_nettype none
// ----
// Printer on the cable
// ----
module ppr_printer_model #(
	parameter int DLY = 120
) (
	input wire logic       strobe_n,  // Strobe.
	input wire logic       feed_n,    // Autofeed.
	input wire logic [7:0] pins,      // Data pins.
	input wire logic       hold_busy, // Bench busy.
	input wire logic       pull_ack,  // Bench acknowledge.
	output logic           busy,      // Busy line.
	output logic           ack_n,     // Acknowledge line.
	output logic [8:0]     last,      // Feed level and byte.
	output int             cnt        // Bytes taken.
);
	logic hs_busy = 1'b0;
	logic hs_ack = 1'b1;
	assign busy = hs_busy | hold_busy;
	assign ack_n = hs_ack & !pull_ack;
	initial cnt = 0;
	// Busy must rise before strobe ends, so DLY stays below the strobe width.
	always @(negedge strobe_n)
	begin
		last = {feed_n, pins};
		cnt++;
		#DLY hs_busy = 1'b1;
		@(posedge strobe_n);
		#DLY hs_ack = 1'b0;
		#DLY hs_busy = 1'b0;
		hs_ack = 1'b1;
	end
endmodule
`default_nettype wire

// ### dv/ppr_port_test.sv
`timescale 1ns/1ns
`default_nettype none
// ----
// Bench
// ----
module ppr_port_test;
	localparam logic [15:0] BASE = 16'h0378;
	logic core_clk = 1'b0;
	logic arst_n = 1'b0;
	logic [15:0] host_addr = 16'h0000;
	logic host_wr = 1'b0;
	logic host_rd = 1'b0;
	logic [7:0] host_wdata = 8'h00;
	logic fault_in_n = 1'b1;
	logic select_status_in = 1'b0;
	logic paper_error_in = 1'b0;
	logic hold_busy = 1'b0;
	logic pull_ack = 1'b0;
	logic dma_q = 1'b0;
	logic dma_tc = 1'b0;
	logic busy_in, acknowledge_in_n, host_rvalid, port_irq, cable_data_pins_oe;
	logic strobe_out_n, autofeed_out_n, initialize_out_n, select_in_out_n, seen, dma_req;
	logic [7:0] host_rdata, cable_data_pins_out, cable_data_pins_in;
	logic [8:0] last;
	int cnt;
	int error_cnt = 0;
	int total_checks = 0;
	always #25 core_clk = ~core_clk;
	assign cable_data_pins_in = cable_data_pins_oe ? cable_data_pins_out : ~cable_data_pins_out;
	ppr_port dut (.core_clk, .arst_n, .port_base(BASE), .host_addr, .host_wr, .host_rd,
		.host_wdata, .dma_cycle_qualifier(dma_q), .dma_ack(dma_q), .dma_tc, .host_rdata,
		.host_rvalid, .dma_req, .port_irq, .cable_data_pins_in, .cable_data_pins_out,
		.cable_data_pins_oe, .fault_in_n, .select_status_in, .paper_error_in, .acknowledge_in_n,
		.busy_in, .strobe_out_n, .autofeed_out_n, .initialize_out_n, .select_in_out_n);
	ppr_printer_model prn (.strobe_n(strobe_out_n), .feed_n(autofeed_out_n),
		.pins(cable_data_pins_out), .hold_busy, .pull_ack, .busy(busy_in),
		.ack_n(acknowledge_in_n), .last, .cnt);
	task chk(input string n, input logic [8:0] e, input logic [8:0] g);
		total_checks++;
		if (g !== e)
		begin
			error_cnt++;
			$display("unexpected %s: expected %h, seen %h", n, e, g);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task wr(input logic [15:0] o, input logic [7:0] d);
		host_addr <= BASE + o;
		host_wdata <= d;
		host_wr <= 1'b1;
		@(posedge core_clk);
		host_wr <= 1'b0;
		@(posedge core_clk);
	endtask
	// Reply stands for one cycle, from the edge after the taken edge.
	task rd(input logic [15:0] o, input logic [7:0] e);
		host_addr <= BASE + o;
		host_rd <= 1'b1;
		@(posedge core_clk);
		host_rd <= 1'b0;
		@(posedge core_clk);
		@(negedge core_clk);
		chk("rvalid", 9'h001, {8'h00, host_rvalid});
		chk("rdata", {1'b0, e}, {1'b0, host_rdata});
		@(posedge core_clk);
	endtask
	task await(input int n);
		for (int k = 0; k < 400 && cnt < n; k++)
			@(posedge core_clk);
	endtask
	task ack_blip;
		tick(10);
		pull_ack <= 1'b1;
		tick(4);
		pull_ack <= 1'b0;
		seen = 1'b0;
		repeat (8)
		begin
			@(posedge core_clk);
			seen = seen | port_irq;
		end
	endtask
	task t_regs;
		rd(16'h0402, 8'h05);
		rd(16'h0000, 8'h00);
		rd(16'h0002, 8'h00);
		wr(16'h0002, 8'hff);
		tick(2);
		rd(16'h0002, 8'h3f);
		chk("pins", 9'h002, {5'h00, strobe_out_n, autofeed_out_n, initialize_out_n, select_in_out_n});
		rd(16'h0003, 8'h00);
		wr(16'h0002, 8'h04);
	endtask
	task t_status;
		select_status_in <= 1'b1;
		hold_busy <= 1'b1;
		tick(12);
		rd(16'h0001, 8'h58);
		fault_in_n <= 1'b0;
		select_status_in <= 1'b0;
		paper_error_in <= 1'b1;
		hold_busy <= 1'b0;
		tick(8);
		rd(16'h0001, 8'he0);
	endtask
	task t_data;
		wr(16'h0000, 8'ha5);
		tick(4);
		chk("pins_out", 9'h0a5, {1'b0, cable_data_pins_out});
		rd(16'h0000, 8'ha5);
		wr(16'h0402, 8'h20);
		wr(16'h0002, 8'h20);
		tick(6);
		rd(16'h0000, 8'h5a);
		chk("oe", 9'h000, {8'h00, cable_data_pins_oe});
	endtask
	task t_fifo;
		wr(16'h0002, 8'h00);
		wr(16'h0402, 8'hc0);
		for (int i = 0; i < 17; i++)
			wr(16'h0400, 8'h10 + i[7:0]);
		rd(16'h0402, 8'hc6);
		wr(16'h0402, 8'hc0);
		for (int i = 0; i < 16; i++)
		begin
			if (i == 7 || i == 8)
				rd(16'h0402, (i == 8) ? 8'hc4 : 8'hc0);
			rd(16'h0400, 8'h10 + i[7:0]);
		end
		rd(16'h0400, 8'h1f);
		rd(16'h0402, 8'hc5);
	endtask
	task t_link;
		wr(16'h0400, 8'h77);
		wr(16'h0402, 8'h00);
		rd(16'h0402, 8'h01);
		wr(16'h0402, 8'h40);
		wr(16'h0400, 8'h3c);
		wr(16'h0400, 8'hc3);
		await(cnt + 1);
		chk("byte", 9'h13c, last);
		await(cnt + 1);
		chk("byte", 9'h1c3, last);
		wr(16'h0402, 8'h60);
		wr(16'h0000, 8'h81);
		wr(16'h0400, 8'h18);
		await(cnt + 1);
		chk("addr", 9'h081, last);
		await(cnt + 1);
		chk("data", 9'h118, last);
	endtask
	task t_irq;
		wr(16'h0402, 8'h00);
		wr(16'h0002, 8'h10);
		ack_blip;
		chk("irq", 9'h001, {8'h00, seen});
		wr(16'h0002, 8'h00);
		ack_blip;
		chk("irq", 9'h000, {8'h00, seen});
	endtask
	task t_modes;
		wr(16'h0402, 8'hc8);
		tick(2);
		chk("dma_req", 9'h001, {8'h00, dma_req});
		dma_q <= 1'b1;
		wr(16'h0000, 8'h5e);
		rd(16'h0000, 8'h5e);
		dma_q <= 1'b0;
		dma_tc <= 1'b1;
		tick(1);
		dma_tc <= 1'b0;
		rd(16'h0402, 8'hcd);
		chk("dma_req", 9'h000, {8'h00, dma_req});
		wr(16'h0402, 8'he0);
		rd(16'h0400, 8'h10);
		rd(16'h0401, 8'h00);
		wr(16'h0002, 8'h20);
		wr(16'h0402, 8'h60);
		pull_ack <= 1'b1;
		tick(6);
		pull_ack <= 1'b0;
		tick(6);
		rd(16'h0400, 8'h5a);
	endtask
	task wrap_up;
		$display("checks %0d, mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial
	begin
		#200000;
		error_cnt++;
		wrap_up;
	end
	initial
	begin
		tick(8);
		arst_n <= 1'b1;
		tick(1);
		t_regs;
		t_status;
		t_data;
		t_fifo;
		t_link;
		t_irq;
		t_modes;
		wrap_up;
	end
endmodule
`default_nettype wire
